/* core/mcw_decoder.v */
// Function
// - ten 16-bit words each way
// - multi-word is thousands then remainder
// - multi-word span limited, overflow indeterminate
// - output format bit picks parameter decoding
// - input format bit picks position encoding
// - endian bit orders signed 32-bit halves
// - act only on zero-to-one command bits
// - no trigger for bits held across mode switch
// - bit 15 selects configuration or command mode
// - bit 14 presets encoder from words 2,3
// - bit 13 runs assembled move, blend/dwell
// - blend direction from second word bit 4
// - bit 10 clears command errors, move-complete
// - bit 9 presets motor position, clears invalid, move-complete
// - bits 8,7 jog; registration option
// - bits 6,5 seek home limit
// - bit 4 halts; invalid only if moving
// - bit 2 holds active move
// - bit 3 resumes; new move cancels hold
// - bits 1,0 relative and absolute moves
// Purpose: decode the host command image into one-cycle motion actions
// Assumes: host image is stable when imageWrite pulses; single clock
// Notes: motion engine outside reports moving and drives the positions
`timescale 1ns/10ps
`include "mcw_defines.vh"
module mcw_decoder (
	input wire ref_clk, // device clock
	input wire arst_n, // asynchronous reset, active low
	input wire imageWrite, // one-cycle strobe: new host image present
	input wire [159:0] hostImage, // ten host words, word 0 in low bits
	input wire binaryOutFmt, // parameters arrive as signed 32-bit
	input wire binaryInFmt, // positions returned as signed 32-bit
	input wire bigEndian, // signed 32-bit high half first
	input wire moveActive, // motion engine is moving
	input wire [31:0] motorPos, // motor position from engine
	input wire [31:0] encoderPos, // encoder position from engine
	input wire [31:0] capturedPos, // captured encoder position
	output reg [159:0] devImage, // ten reported words
	output reg configMode, // 1 while in configuration mode
	output reg presetEncoder, // pulse: load encoder position
	output reg runAssembled, // pulse: start assembled move
	output reg assembledDwell, // assembled move is dwell type
	output reg blendReverse, // blend move counter-clockwise
	output reg [15:0] dwellMs, // dwell time in milliseconds
	output reg resetErrors, // pulse: clear command errors
	output reg presetMotor, // pulse: preset motor position
	output reg load_from_feedback_sel, // preset source is encoder
	output reg jog_reverse_cmd, // pulse: jog counter-clockwise
	output reg jog_forward_cmd, // pulse: jog clockwise
	output reg jogRegistration, // jog runs as registration move
	output reg seek_origin_reverse_cmd, // pulse: seek home reverse
	output reg seek_origin_forward_cmd, // pulse: seek home forward
	output reg immediateStop, // pulse: stop without deceleration
	output reg holdMove, // pulse: hold active move
	output reg resumeMove, // pulse: resume held move
	output reg relativeMove, // pulse: start relative move
	output reg absoluteMove, // pulse: start absolute move
	output reg [31:0] paramValue, // words 2,3 decoded to binary
	output reg moveComplete, // move-complete flag
	output reg positionInvalid, // motor position invalid flag
	output reg commandError, // command error flag
	output reg moveHeld, // a move sits in hold
	output reg positionOverflow // multi-word position beyond its span
);
	// ----------------------------------------
	// host word split and parameter decode
	// ----------------------------------------
	wire [15:0] cmdWord = hostImage[`MCW_CMD0_LSB +: `MCW_W];
	wire [15:0] cmdWord2 = hostImage[`MCW_CMD1_LSB +: `MCW_W];
	wire [15:0] parHi = hostImage[`MCW_PAR_A_LSB +: `MCW_W];
	wire [15:0] parLo = hostImage[`MCW_PAR_B_LSB +: `MCW_W];
	wire [15:0] dwellWord = hostImage[`MCW_DWELL_LSB +: `MCW_W];
	wire [31:0] paramBin;
	mcw_to_binary uParam (
		.firstWord(parHi),
		.secondWord(parLo),
		.binaryFmt(binaryOutFmt),
		.bigEndian(bigEndian),
		.value(paramBin)
	);

	// ----------------------------------------
	// edge detection against previous write
	// ----------------------------------------
	reg [15:0] prevCmd_q;
	// mode bit changes never count; bits held across a switch see old value high
	wire [15:0] rise = cmdWord & ~prevCmd_q;
	wire cmdMode = ~cmdWord[`MCW_B_MODE];
	wire fire = imageWrite & cmdMode;
	wire anyMove = rise[`MCW_B_RUN_ASSM] | rise[`MCW_B_JOG_REV] | rise[`MCW_B_JOG_FWD] |
		rise[`MCW_B_SEEK_REV] | rise[`MCW_B_SEEK_FWD] | rise[`MCW_B_REL] | rise[`MCW_B_ABS];
	// more than one rising bit is a host fault; flagged, nothing launched
	wire [4:0] riseCount;
	genvar gi;
	wire [4:0] partial [0:16];
	assign partial[0] = 5'h00;
	generate
		for (gi = 0; gi < `MCW_B_MODE; gi = gi + 1) begin : gCount
			assign partial[gi+1] = partial[gi] + {4'h0, rise[gi]};
		end
	endgenerate
	assign partial[16] = partial[15];
	assign riseCount = partial[16];
	wire multiRise = (riseCount > 5'h01);
	wire go = fire & ~multiRise;

	// ----------------------------------------
	// command pulses and latched modifiers
	// ----------------------------------------
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			prevCmd_q <= `MCW_ZERO16;
			configMode <= 1'b0;
			presetEncoder <= 1'b0;
			runAssembled <= 1'b0;
			assembledDwell <= 1'b0;
			blendReverse <= 1'b0;
			dwellMs <= `MCW_ZERO16;
			resetErrors <= 1'b0;
			presetMotor <= 1'b0;
			load_from_feedback_sel <= 1'b0;
			jog_reverse_cmd <= 1'b0;
			jog_forward_cmd <= 1'b0;
			jogRegistration <= 1'b0;
			seek_origin_reverse_cmd <= 1'b0;
			seek_origin_forward_cmd <= 1'b0;
			immediateStop <= 1'b0;
			holdMove <= 1'b0;
			resumeMove <= 1'b0;
			relativeMove <= 1'b0;
			absoluteMove <= 1'b0;
			paramValue <= `MCW_ZERO32;
		end else begin
			presetEncoder <= go & rise[`MCW_B_PRESET_ENC];
			runAssembled <= go & rise[`MCW_B_RUN_ASSM];
			resetErrors <= go & rise[`MCW_B_RESET_ERR];
			presetMotor <= go & rise[`MCW_B_PRESET_POS];
			jog_reverse_cmd <= go & rise[`MCW_B_JOG_REV];
			jog_forward_cmd <= go & rise[`MCW_B_JOG_FWD];
			seek_origin_reverse_cmd <= go & rise[`MCW_B_SEEK_REV];
			seek_origin_forward_cmd <= go & rise[`MCW_B_SEEK_FWD];
			immediateStop <= go & rise[`MCW_B_ISTOP];
			holdMove <= go & rise[`MCW_B_HOLD];
			resumeMove <= go & rise[`MCW_B_RESUME];
			relativeMove <= go & rise[`MCW_B_REL];
			absoluteMove <= go & rise[`MCW_B_ABS];
			if (imageWrite) begin
				prevCmd_q <= cmdWord;
				configMode <= cmdWord[`MCW_B_MODE];
			end
			if (go && anyMove) begin
				assembledDwell <= cmdWord2[`MCW_B2_DWELL];
				blendReverse <= cmdWord2[`MCW_B2_REVBLEND];
				jogRegistration <= cmdWord2[`MCW_B2_REG];
				dwellMs <= dwellWord;
				paramValue <= paramBin;
			end
			if (go && (rise[`MCW_B_PRESET_ENC] || rise[`MCW_B_PRESET_POS])) begin
				paramValue <= paramBin;
				load_from_feedback_sel <= cmdWord2[`MCW_B2_FEEDBACK];
			end
		end
	end

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	reg moveActivePrev_q;
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			moveActivePrev_q <= 1'b0;
			moveComplete <= 1'b0;
			positionInvalid <= 1'b0;
			commandError <= 1'b0;
			moveHeld <= 1'b0;
		end else begin
			moveActivePrev_q <= moveActive;
			// set wins over clear throughout
			if (moveActivePrev_q && !moveActive && !moveHeld)
				moveComplete <= 1'b1;
			else if (go && (rise[`MCW_B_RESET_ERR] || rise[`MCW_B_PRESET_POS]))
				moveComplete <= 1'b0;
			if (go && rise[`MCW_B_ISTOP] && moveActive)
				positionInvalid <= 1'b1;
			else if (go && rise[`MCW_B_PRESET_POS])
				positionInvalid <= 1'b0;
			if (fire && multiRise)
				commandError <= 1'b1;
			else if (go && rise[`MCW_B_RESET_ERR])
				commandError <= 1'b0;
			if (go && rise[`MCW_B_HOLD] && moveActive)
				moveHeld <= 1'b1;
			else if (go && (rise[`MCW_B_RESUME] || anyMove || rise[`MCW_B_ISTOP]))
				moveHeld <= 1'b0;
		end
	end

	// ----------------------------------------
	// returned positions
	// ----------------------------------------
	wire [15:0] mpA, mpB, epA, epB, cpA, cpB;
	wire mpOk, epOk, cpOk;
	mcw_from_binary uMotor (
		.value(motorPos),
		.binaryFmt(binaryInFmt),
		.bigEndian(bigEndian),
		.firstWord(mpA),
		.secondWord(mpB),
		.inRange(mpOk)
	);
	mcw_from_binary uEnc (
		.value(encoderPos),
		.binaryFmt(binaryInFmt),
		.bigEndian(bigEndian),
		.firstWord(epA),
		.secondWord(epB),
		.inRange(epOk)
	);
	mcw_from_binary uCap (
		.value(capturedPos),
		.binaryFmt(binaryInFmt),
		.bigEndian(bigEndian),
		.firstWord(cpA),
		.secondWord(cpB),
		.inRange(cpOk)
	);
	wire [15:0] statusWord = {configMode, `MCW_STATUS_PAD, moveHeld, positionInvalid,
		commandError, moveComplete, moveActive, positionOverflow};
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			devImage <= `MCW_ZERO_IMG;
			positionOverflow <= 1'b0;
		end else begin
			positionOverflow <= ~binaryInFmt & ~(mpOk & epOk & cpOk);
			devImage <= {`MCW_ZERO16, `MCW_ZERO16, `MCW_ZERO16, cpB, cpA, epB, epA,
				mpB, mpA, statusWord};
		end
	end
endmodule // mcw_decoder

/* core/mcw_defines.vh */
// Purpose: shared constants for the motion command word decoder
// Assumes: ten 16-bit words each way, one device clock
// Notes: bit positions of the first and second command words
`ifndef MCW_DEFINES_VH
`define MCW_DEFINES_VH
`define MCW_WORDS 10
`define MCW_W 16
`define MCW_B_MODE 15
`define MCW_B_PRESET_ENC 14
`define MCW_B_RUN_ASSM 13
`define MCW_B_RESET_ERR 10
`define MCW_B_PRESET_POS 9
`define MCW_B_JOG_REV 8
`define MCW_B_JOG_FWD 7
`define MCW_B_SEEK_REV 6
`define MCW_B_SEEK_FWD 5
`define MCW_B_ISTOP 4
`define MCW_B_RESUME 3
`define MCW_B_HOLD 2
`define MCW_B_REL 1
`define MCW_B_ABS 0
`define MCW_B2_DWELL 9
`define MCW_B2_REG 7
`define MCW_B2_REVBLEND 4
`define MCW_B2_FEEDBACK 13
`define MCW_THOUSAND 32'sh000003E8
`define MCW_MW_MIN 32'shFE0C0000
`define MCW_MW_MAX 32'sh01F3FFFF
`define MCW_ZERO16 16'h0000
`define MCW_ZERO32 32'h00000000
`define MCW_ZERO_IMG 160'h0
`define MCW_STATUS_PAD 9'h000
`define MCW_CMD0_LSB 0
`define MCW_CMD1_LSB 16
`define MCW_PAR_A_LSB 32
`define MCW_PAR_B_LSB 48
`define MCW_DWELL_LSB 144
`endif

/* core/mcw_to_binary.v */
// Purpose: multi-word or signed 32-bit pair into a binary value
// Assumes: words come straight from the host image
// Notes: purely combinational
`timescale 1ns/10ps
`include "mcw_defines.vh"
module mcw_to_binary (
	input wire [15:0] firstWord, // first word of the pair
	input wire [15:0] secondWord, // second word of the pair
	input wire binaryFmt, // 1 selects signed 32-bit
	input wire bigEndian, // 1 puts high half first
	output reg [31:0] value // decoded value
);
	wire signed [31:0] hiExt = {{16{firstWord[15]}}, firstWord};
	wire signed [31:0] loExt = {{16{secondWord[15]}}, secondWord};
	wire signed [31:0] product = hiExt * `MCW_THOUSAND;
	always @* begin
		if (!binaryFmt)
			value = product + loExt;
		else if (bigEndian)
			value = {firstWord, secondWord};
		else
			value = {secondWord, firstWord};
	end
endmodule // mcw_to_binary

/* core/mcw_from_binary.v */
// Purpose: binary position into the host word pair
// Assumes: value is a signed 32-bit position
// Notes: out-of-range multi-word results are not meaningful
`timescale 1ns/10ps
`include "mcw_defines.vh"
module mcw_from_binary (
	input wire [31:0] value, // position to report
	input wire binaryFmt, // 1 selects signed 32-bit
	input wire bigEndian, // 1 puts high half first
	output reg [15:0] firstWord, // first reported word
	output reg [15:0] secondWord, // second reported word
	output wire inRange // value fits the multi-word span
);
	wire signed [31:0] sv = value;
	wire signed [31:0] quo = sv / `MCW_THOUSAND;
	wire signed [31:0] rem = sv % `MCW_THOUSAND;
	assign inRange = (sv >= `MCW_MW_MIN) && (sv <= `MCW_MW_MAX);
	always @* begin
		if (!binaryFmt) begin
			firstWord = quo[15:0];
			secondWord = rem[15:0];
		end else if (bigEndian) begin
			firstWord = value[31:16];
			secondWord = value[15:0];
		end else begin
			firstWord = value[15:0];
			secondWord = value[31:16];
		end
	end
endmodule // mcw_from_binary

/* bench/mcw_host_model.sv */
// Purpose: host controller side of the cyclic exchange
// Assumes: writes launched at the falling edge
// Notes: between writes the image shows the inverse of the last one
`timescale 1ns/10ps
module mcw_host_model (
	input logic ref_clk, // device clock
	output logic imageWrite, // one-cycle write strobe
	output logic [159:0] hostImage // ten host words
);
	initial begin
		imageWrite = 1'b0;
		hostImage = 160'h0;
	end
	// one write of ten 16-bit words, optionally after idle cycles
	task automatic sendImage(input logic [159:0] img, input int idle);
		repeat (idle) @(negedge ref_clk);
		@(negedge ref_clk);
		imageWrite = 1'b1;
		hostImage = img;
		@(negedge ref_clk);
		imageWrite = 1'b0;
		hostImage = ~img;
	endtask
endmodule // mcw_host_model

/* bench/mcw_decoder_checker.sv */
// Purpose: timing checks on the command word decoder
// Assumes: one clock, asynchronous active-low reset
// Notes: keeps its own copy of the last written command word
`timescale 1ns/10ps
module mcw_decoder_checker (
	input logic ref_clk, // device clock
	input logic arst_n, // reset, active low
	input logic imageWrite, // host write strobe
	input logic [159:0] hostImage, // host words
	input logic binaryOutFmt, // binary parameters
	input logic bigEndian, // high half first
	input logic moveActive, // engine moving
	input logic absoluteMove, // absolute launch
	input logic relativeMove, // relative launch
	input logic immediateStop, // stop launch
	input logic presetMotor, // preset launch
	input logic configMode, // mode flag
	input logic [31:0] paramValue, // decoded words 2,3
	input logic positionInvalid, // position invalid flag
	input logic commandError // command error flag
);
	logic [15:0] prevQ;
	wire [15:0] riseW = hostImage[15:0] & ~prevQ;
	wire cmdW = imageWrite && !hostImage[15];
	wire multiW = (riseW[14:0] & (riseW[14:0] - 15'h0001)) != 15'h0000;
	wire signed [31:0] mwVal = $signed(hostImage[47:32]) * 32'sh000003E8
		+ $signed(hostImage[63:48]);
	wire [31:0] binVal = bigEndian ? {hostImage[47:32], hostImage[63:48]} : hostImage[63:32];
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) prevQ <= 16'h0000;
		else if (imageWrite) prevQ <= hostImage[15:0];
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence sLaunch(int b);
		cmdW && riseW[14:0] == (15'h0001 << b);
	endsequence
	sequence sAbsFmt(bit f);
		cmdW && riseW[14:0] == 15'h0001 && binaryOutFmt == f;
	endsequence
	sequence sStop(bit m);
		cmdW && riseW[14:0] == 15'h0010 && moveActive == m;
	endsequence
	AST_ABS_LAUNCH: assert property (sLaunch(0) |=> absoluteMove)
		else $error("absolute move not launched");
	AST_REL_LAUNCH: assert property (sLaunch(1) |=> relativeMove)
		else $error("relative move not launched");
	AST_NO_RETRIGGER: assert property (!(cmdW && riseW[0]) |=> !absoluteMove)
		else $error("absolute move without a rising bit");
	AST_CONFIG_QUIET: assert property (imageWrite && hostImage[15] |=> !absoluteMove && !relativeMove && !immediateStop)
		else $error("launch from a configuration write");
	AST_MODE: assert property (imageWrite |=> configMode == $past(hostImage[15]))
		else $error("mode flag does not follow bit 15");
	AST_MULTI_ERR: assert property (cmdW && multiW |=> commandError && !absoluteMove)
		else $error("several rising bits not refused");
	AST_MW_PARAM: assert property (sAbsFmt(0) |=> paramValue == $past(mwVal))
		else $error("multi-word parameter wrong");
	AST_BIN_PARAM: assert property (sAbsFmt(1) |=> paramValue == $past(binVal))
		else $error("binary parameter wrong");
	AST_STOP_MOVING: assert property (sStop(1) |=> immediateStop && positionInvalid)
		else $error("stop while moving left position valid");
	AST_STOP_IDLE: assert property (sStop(0) |=> positionInvalid == $past(positionInvalid))
		else $error("idle stop changed position validity");
	AST_PRESET_CLEAR: assert property (presetMotor |-> !positionInvalid)
		else $error("preset left position invalid");
endmodule // mcw_decoder_checker
bind mcw_decoder mcw_decoder_checker chk (.ref_clk, .arst_n, .imageWrite, .hostImage,
	.binaryOutFmt, .bigEndian, .moveActive, .absoluteMove, .relativeMove, .immediateStop,
	.presetMotor, .configMode, .paramValue, .positionInvalid, .commandError);

/* bench/tb_top.sv */
// Purpose: self-checking bench for the command word decoder
// Assumes: host writes go through the host model
// Notes: pulses are sampled at the falling edge after the taking edge
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic binaryOutFmt = 1'b0, binaryInFmt = 1'b0, bigEndian = 1'b0, moveActive = 1'b0;
	logic [31:0] motorPos = 32'h0, encoderPos = 32'h0, capturedPos = 32'h0, paramValue;
	logic [159:0] hostImage, devImage;
	logic [15:0] dwellMs;
	logic imageWrite, configMode, presetEncoder, runAssembled, assembledDwell, blendReverse;
	logic resetErrors, presetMotor, load_from_feedback_sel, jog_reverse_cmd, jog_forward_cmd;
	logic seek_origin_reverse_cmd, seek_origin_forward_cmd, immediateStop, holdMove, resumeMove;
	logic relativeMove, absoluteMove, moveComplete, positionInvalid, commandError, moveHeld;
	logic jogRegistration, positionOverflow;
	int n_fail = 0, checks_done = 0, cycles = 0;
	wire [14:0] pulses = {presetEncoder, runAssembled, 2'h0, resetErrors, presetMotor,
		jog_reverse_cmd, jog_forward_cmd, seek_origin_reverse_cmd, seek_origin_forward_cmd,
		immediateStop, resumeMove, holdMove, relativeMove, absoluteMove};
	always #25 ref_clk = ~ref_clk;
	mcw_host_model host (.ref_clk, .imageWrite, .hostImage);
	mcw_decoder dut (.ref_clk, .arst_n, .imageWrite, .hostImage, .binaryOutFmt, .binaryInFmt,
		.bigEndian, .moveActive, .motorPos, .encoderPos, .capturedPos, .devImage, .configMode,
		.presetEncoder, .runAssembled, .assembledDwell, .blendReverse, .dwellMs, .resetErrors,
		.presetMotor, .load_from_feedback_sel, .jog_reverse_cmd, .jog_forward_cmd,
		.jogRegistration, .seek_origin_reverse_cmd, .seek_origin_forward_cmd, .immediateStop,
		.holdMove, .resumeMove, .relativeMove, .absoluteMove, .paramValue, .moveComplete,
		.positionInvalid, .commandError, .moveHeld, .positionOverflow);
	task automatic send(input logic [15:0] w0, input logic [15:0] w1 = 16'h0,
		input logic [31:0] w23 = 32'h0, input logic [15:0] w9 = 16'h0);
		host.sendImage({w9, 80'h0, w23, w1, w0}, w0 == 16'h0 ? 2 : 0);
	endtask
	task automatic checkParam(input logic f, input logic big, input logic [31:0] w23,
		input logic [31:0] e);
		binaryOutFmt = f;
		bigEndian = big;
		send(16'h0000);
		send(16'h0001, 16'h0000, w23);
		`CHK("param", e, paramValue)
	endtask
	task automatic checkPos(input logic f, input logic big, input logic [31:0] p,
		input logic [31:0] e);
		binaryInFmt = f;
		bigEndian = big;
		motorPos = p;
		encoderPos = p;
		capturedPos = p;
		repeat (3) @(negedge ref_clk);
		`CHK("motor words", e, devImage[47:16])
		`CHK("encoder words", e, devImage[79:48])
		`CHK("captured words", e, devImage[111:80])
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			complete_run();
		end
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		@(negedge ref_clk);
		arst_n = 1'b1;
		for (int b = 0; b < 15; b++) begin
			if (b != 11 && b != 12) begin
				send(16'h0001 << b);
				`CHK("launch", 15'h0001 << b, pulses)
				send(16'h0000);
			end
		end
		send(16'h0001);
		send(16'h0001);
		`CHK("held bit", 15'h0000, pulses)
		// reset in mid-run forgets the held bit, so the same word fires again
		arst_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		arst_n = 1'b1;
		send(16'h0001);
		`CHK("after reset", 15'h0001, pulses)
		send(16'h8002);
		`CHK("config mode", 1'b1, configMode)
		send(16'h0002);
		`CHK("mode switch", 15'h0000, pulses)
		`CHK("command mode", 1'b0, configMode)
		send(16'h0000);
		send(16'h0003);
		`CHK("two bits", 15'h0000, pulses)
		`CHK("two bits error", 1'b1, commandError)
		send(16'h0010);
		`CHK("idle stop", 1'b0, positionInvalid)
		moveActive = 1'b1;
		send(16'h0000);
		send(16'h0004);
		`CHK("held", 1'b1, moveHeld)
		send(16'h0000);
		send(16'h0008);
		`CHK("resumed", 1'b0, moveHeld)
		send(16'h0000);
		send(16'h0004);
		`CHK("held again", 1'b1, moveHeld)
		send(16'h0000);
		send(16'h0002);
		`CHK("hold cancelled", 1'b0, moveHeld)
		send(16'h0000);
		send(16'h0010);
		`CHK("moving stop", 1'b1, positionInvalid)
		moveActive = 1'b0;
		send(16'h0000);
		`CHK("move done", 1'b1, moveComplete)
		send(16'h0400);
		`CHK("errors cleared", 1'b0, commandError)
		`CHK("complete cleared", 1'b0, moveComplete)
		`CHK("invalid kept", 1'b1, positionInvalid)
		send(16'h0000);
		send(16'h0200, 16'h2000);
		`CHK("preset clears", 1'b0, positionInvalid)
		`CHK("preset source", 1'b1, load_from_feedback_sel)
		send(16'h0000);
		send(16'h2000, 16'h0210, 32'h0, 16'h0064);
		`CHK("dwell type", 1'b1, assembledDwell)
		`CHK("dwell time", 16'h0064, dwellMs)
		`CHK("blend reverse", 1'b1, blendReverse)
		send(16'h0000);
		send(16'h0080, 16'h0080);
		`CHK("registration", 1'b1, jogRegistration)
		checkParam(1'b0, 1'b0, {16'h0237, 16'h04D2}, 32'h0012D687);
		checkParam(1'b0, 1'b0, {16'hFEBF, 16'hE21A}, 32'hFF8B344F);
		checkParam(1'b1, 1'b0, {16'h0012, 16'hD687}, 32'h0012D687);
		checkParam(1'b1, 1'b1, {16'hD687, 16'h0012}, 32'h0012D687);
		checkPos(1'b0, 1'b0, 32'h0012D687, {16'h0237, 16'h04D2});
		checkPos(1'b1, 1'b0, 32'h0012D687, 32'h0012D687);
		checkPos(1'b1, 1'b1, 32'h0012D687, 32'hD6870012);
		checkPos(1'b0, 1'b0, 32'h01F3FFFF, {16'h03E7, 16'h7FFF});
		`CHK("in span", 1'b0, positionOverflow)
		checkPos(1'b1, 1'b0, 32'hFE0BFFFF, 32'hFE0BFFFF);
		`CHK("binary no overflow", 1'b0, positionOverflow)
		binaryInFmt = 1'b0;
		repeat (3) @(negedge ref_clk);
		`CHK("below span", 1'b1, positionOverflow)
		`CHK("status overflow", 1'b1, devImage[0])
		complete_run();
	end
endmodule // tb_top
